// ===== dsc_pkg.sv
// dsc_pkg: constants for the dds serial configuration port
// assumes: used by dsc_port and dsc_shifter, one clock domain MCLK_I
package dsc_pkg;
    // byte buffer size, parallel byte addresses 0x00..0x27
    localparam int NUM_BYTES = 40;
    localparam logic [5:0] LAST_BYTE = 6'h27;
    // serial register base byte, byte count is the gap to the next base
    localparam logic [5:0] BASE_PH1 = 6'h00;
    localparam logic [5:0] BASE_PH2 = 6'h02;
    localparam logic [5:0] BASE_FTW1 = 6'h04;
    localparam logic [5:0] BASE_FTW2 = 6'h0a;
    localparam logic [5:0] BASE_STEP = 6'h10;
    localparam logic [5:0] BASE_UPD = 6'h16;
    localparam logic [5:0] BASE_RAMP = 6'h1a;
    localparam logic [5:0] BASE_CTRL = 6'h1d;
    localparam logic [5:0] BASE_KMUL = 6'h21;
    localparam logic [5:0] BASE_UNUSED = 6'h23;
    localparam logic [5:0] BASE_KRAMP = 6'h25;
    localparam logic [5:0] BASE_AUX = 6'h26;
    // control byte addresses
    localparam logic [5:0] ADDR_PWR = 6'h1d;
    localparam logic [5:0] ADDR_CMUL = 6'h1e;
    localparam logic [5:0] ADDR_MODE = 6'h1f;
    localparam logic [5:0] ADDR_OUT = 6'h20;
    // reset values
    localparam logic [7:0] RST_PWR = 8'h10;
    localparam logic [7:0] RST_CMUL = 8'h64;
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [7:0] RST_OUT = 8'h20;
    localparam logic [7:0] RST_KRAMP = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // field positions
    localparam int MODE_CLR1 = 7;
    localparam int MODE_CLR2 = 6;
    localparam int MODE_TRI = 5;
    localparam int MODE_SEL_HI = 3;
    localparam int MODE_SEL_LO = 1;
    localparam int MODE_INTUPD = 0;
    localparam int CMUL_RANGE = 6;
    localparam int CMUL_BYP = 5;
    localparam int CMUL_HI = 4;
    localparam int OUT_SINC = 6;
    localparam int OUT_KEN = 5;
    localparam int OUT_KINT = 4;
    localparam int OUT_LSB = 1;
    localparam int OUT_SDO = 0;
    localparam int PWR_CMP = 4;
    localparam int PWR_RSVD = 3;
    localparam int PWR_AUX = 2;
    localparam int PWR_DAC = 1;
    localparam int PWR_DIG = 0;
    localparam int PH_TOP = 7;
    localparam int PH_KEEP = 6;
    localparam int INSTR_RD = 7;
    // bit counter value of the last bit of any byte, bits 0 to 7
    localparam logic [2:0] LAST_BIT = 3'h7;
    // serial clock limit and system clock period
    localparam int SCLK_MAX_MHZ = 10;
    localparam int MCLK_NS = 100;
endpackage

// ===== dsc_shifter.sv
// dsc_shifter: serial clock edge finder, bit shifter and cycle sequencer
// assumes: sclk, sdio, cs, io reset already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module dsc_shifter
    import dsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic cs_n_i,
    input wire logic io_rst_i,
    input wire logic lsb_first_i,
    input wire logic [7:0] rd_byte_i,
    output logic rise_o,
    output logic fall_o,
    output logic instr_done_o,
    output logic byte_done_o,
    output logic [7:0] byte_o,
    output logic sdo_o,
    output logic phase_data_o
);
    logic sclk_d;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] out_reg;
    logic [2:0] out_cnt;

    // ----------------------------------------
    // edge detect on sampled serial clock
    // ----------------------------------------
    // chip select high suspends the cycle, edges ignored
    assign rise_o = sclk_i & ~sclk_d & ~cs_n_i & ~io_rst_i;
    assign fall_o = ~sclk_i & sclk_d & ~cs_n_i & ~io_rst_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_i;
        end
    end

    // ----------------------------------------
    // input shift
    // ----------------------------------------
    // sample on rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (io_rst_i) begin
            bit_cnt <= 3'h0;
        end else if (rise_o) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (lsb_first_i && phase_data_o) begin
                shreg <= {sdi_i, shreg[7:1]};
            end else begin
                shreg <= {shreg[6:0], sdi_i};
            end
        end
    end

    // instruction byte always msb first keeps the r/w bit in front
    assign byte_done_o = rise_o && (bit_cnt == LAST_BIT) && phase_data_o;
    assign instr_done_o = rise_o && (bit_cnt == LAST_BIT) && !phase_data_o;
    assign byte_o = (lsb_first_i && phase_data_o) ? {sdi_i, shreg[7:1]} : {shreg[6:0], sdi_i};

    // ----------------------------------------
    // phase tracking
    // ----------------------------------------
    // io reset aborts, next 8 edges instruction
    // parent also pulses io_rst_i once the last byte of a register is in
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_data_o <= 1'b0;
        end else if (io_rst_i) begin
            phase_data_o <= 1'b0;
        end else if (instr_done_o) begin
            phase_data_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // output shift
    // ----------------------------------------
    // drive out on falling edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_reg <= 8'h00;
            out_cnt <= 3'h0;
            sdo_o <= 1'b0;
        end else if (io_rst_i) begin
            out_cnt <= 3'h0;
        end else if (fall_o && phase_data_o) begin
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                sdo_o <= lsb_first_i ? rd_byte_i[0] : rd_byte_i[7];
                out_reg <= lsb_first_i ? {1'b0, rd_byte_i[7:1]} : {rd_byte_i[6:0], 1'b0};
            end else begin
                sdo_o <= lsb_first_i ? out_reg[0] : out_reg[7];
                out_reg <= lsb_first_i ? {1'b0, out_reg[7:1]} : {out_reg[6:0], 1'b0};
            end
        end else if (!phase_data_o) begin
            out_cnt <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// ===== dsc_port.sv
// dsc_port: serial programming port with buffer and active register bank
// assumes: host drives SCLK_I at most 10 MHz, pins are asynchronous to MCLK_I
`timescale 1ns/1ps
`default_nettype none
module dsc_port
    import dsc_pkg::*;
#(
    parameter int UPD_WIDTH = 32
)(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic SERIAL_SEL_N_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic IO_RESET_I,
    input wire logic SDIO_I,
    output logic SDIO_O,
    output logic SDIO_OE_O,
    output logic SERIAL_OUTPUT_LINE_O,
    output logic SERIAL_OUTPUT_LINE_OE_O,
    input wire logic UPDATE_I,
    input wire logic REFERENCE_CLOCK_RUN_I,
    output logic [13:0] PHASE_ONE_O,
    output logic [13:0] PHASE_TWO_O,
    output logic [47:0] TUNING_ONE_O,
    output logic [47:0] TUNING_TWO_O,
    output logic [47:0] SWEEP_STEP_O,
    output logic [UPD_WIDTH-1:0] UPDATE_PERIOD_O,
    output logic [19:0] SWEEP_PERIOD_O,
    output logic [7:0] POWER_DOWN_O,
    output logic [7:0] CLOCK_MULT_O,
    output logic [7:0] MODE_O,
    output logic [7:0] OUTPUT_CTRL_O,
    output logic [11:0] KEYING_MULT_O,
    output logic [7:0] KEYING_RAMP_O,
    output logic [11:0] AUX_VALUE_O
);
    logic [7:0] buffer [NUM_BYTES];
    logic [7:0] bank [NUM_BYTES];
    logic [1:0] s_sclk, s_sdi, s_cs, s_iorst, s_sel, s_upd, s_ref;
    logic upd_d, ref_d, do_copy;
    logic rise, fall, instr_done, byte_done, phase_data, sdo_bit;
    logic [7:0] in_byte, rd_byte;
    logic rd_mode;
    logic [5:0] ptr, last_ptr;
    logic sel_rst, port_en;
    logic cycle_end;

    // ----------------------------------------
    // register map decode
    // ----------------------------------------
    // byte range per serial address
    function automatic logic [5:0] base_of(input logic [3:0] a);
        case (a)
            4'h0: base_of = BASE_PH1;
            4'h1: base_of = BASE_PH2;
            4'h2: base_of = BASE_FTW1;
            4'h3: base_of = BASE_FTW2;
            4'h4: base_of = BASE_STEP;
            4'h5: base_of = BASE_UPD;
            4'h6: base_of = BASE_RAMP;
            4'h7: base_of = BASE_CTRL;
            4'h8: base_of = BASE_KMUL;
            4'h9: base_of = BASE_UNUSED;
            4'ha: base_of = BASE_KRAMP;
            default: base_of = BASE_AUX;
        endcase
    endfunction

    function automatic logic [7:0] rst_of(input int i);
        if (i == int'(ADDR_PWR)) rst_of = RST_PWR;
        else if (i == int'(ADDR_CMUL)) rst_of = RST_CMUL;
        else if (i == int'(ADDR_MODE)) rst_of = RST_MODE;
        else if (i == int'(ADDR_OUT)) rst_of = RST_OUT;
        else if (i == int'(BASE_KRAMP)) rst_of = RST_KRAMP;
        else rst_of = RST_ZERO;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s_sclk <= 2'b00;
            s_sdi <= 2'b00;
            s_cs <= 2'b11;
            s_iorst <= 2'b00;
            s_sel <= 2'b11;
            s_upd <= 2'b00;
            s_ref <= 2'b00;
        end else begin
            s_sclk <= {s_sclk[0], SCLK_I};
            s_sdi <= {s_sdi[0], SDIO_I};
            s_cs <= {s_cs[0], CS_N_I};
            s_iorst <= {s_iorst[0], IO_RESET_I};
            s_sel <= {s_sel[0], SERIAL_SEL_N_I};
            s_upd <= {s_upd[0], UPDATE_I};
            s_ref <= {s_ref[0], REFERENCE_CLOCK_RUN_I};
        end
    end

    // strap high holds port in reset
    assign port_en = ~s_sel[1];
    assign sel_rst = s_iorst[1] | ~port_en | cycle_end;

    dsc_shifter u_shift (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .sclk_i(s_sclk[1]),
        .sdi_i(s_sdi[1]),
        .cs_n_i(s_cs[1] | ~port_en),
        .io_rst_i(sel_rst),
        .lsb_first_i(bank[ADDR_OUT][OUT_LSB]),
        .rd_byte_i(rd_byte),
        .rise_o(rise),
        .fall_o(fall),
        .instr_done_o(instr_done),
        .byte_done_o(byte_done),
        .byte_o(in_byte),
        .sdo_o(sdo_bit),
        .phase_data_o(phase_data)
    );

    // ----------------------------------------
    // transfer sequencing
    // ----------------------------------------
    // decode instruction byte
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rd_mode <= 1'b0;
            ptr <= 6'h00;
            last_ptr <= 6'h00;
        end else if (instr_done) begin
            rd_mode <= in_byte[INSTR_RD];
            ptr <= base_of(in_byte[3:0]);
            if (in_byte[3:0] >= 4'hb) begin
                last_ptr <= LAST_BYTE;
            end else begin
                last_ptr <= base_of(in_byte[3:0] + 4'h1) - 6'h01;
            end
        end else if (byte_done && ptr != last_ptr) begin
            ptr <= ptr + 6'h01;
        end
    end

    // last byte in closes the cycle, next eight edges are an instruction
    // registered, so the close cannot loop back through the edge gates
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cycle_end <= 1'b0;
        end else begin
            cycle_end <= byte_done && (ptr == last_ptr);
        end
    end

    always_comb begin
        rd_byte = buffer[ptr];
        if (ptr == ADDR_PWR) begin
            rd_byte[PWR_RSVD] = 1'b0;
        end
    end

    // ----------------------------------------
    // buffer memory
    // ----------------------------------------
    // writes fill each byte in turn
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                buffer[i] <= rst_of(i);
            end
        end else if (byte_done && !rd_mode) begin
            buffer[ptr] <= in_byte;
        end
    end

    // ----------------------------------------
    // update to active bank
    // ----------------------------------------
    // internal rate timer is outside this block; internal mode uses same pin
    // reference clock start copies the buffer
    assign do_copy = (s_upd[1] & ~upd_d) | (s_ref[1] & ~ref_d);

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            upd_d <= 1'b0;
            ref_d <= 1'b0;
        end else begin
            upd_d <= s_upd[1];
            ref_d <= s_ref[1];
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                bank[i] <= rst_of(i);
            end
        end else if (do_copy) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                bank[i] <= buffer[i];
            end
        end
    end

    // ----------------------------------------
    // output pins
    // ----------------------------------------
    // two-wire or three-wire selection
    always_comb begin
        SDIO_O = sdo_bit;
        SERIAL_OUTPUT_LINE_O = sdo_bit;
        SDIO_OE_O = 1'b0;
        SERIAL_OUTPUT_LINE_OE_O = 1'b0;
        if (phase_data && rd_mode && !s_cs[1] && port_en) begin
            if (bank[ADDR_OUT][OUT_SDO]) begin
                SERIAL_OUTPUT_LINE_OE_O = 1'b1;
            end else begin
                SDIO_OE_O = 1'b1;
            end
        end
    end

    assign PHASE_ONE_O = {bank[BASE_PH1][PH_KEEP-1:0], bank[BASE_PH1+6'h01]};
    assign PHASE_TWO_O = {bank[BASE_PH2][PH_KEEP-1:0], bank[BASE_PH2+6'h01]};
    assign TUNING_ONE_O = {bank[4], bank[5], bank[6], bank[7], bank[8], bank[9]};
    assign TUNING_TWO_O = {bank[10], bank[11], bank[12], bank[13], bank[14], bank[15]};
    assign SWEEP_STEP_O = {bank[16], bank[17], bank[18], bank[19], bank[20], bank[21]};
    assign UPDATE_PERIOD_O = UPD_WIDTH'({bank[22], bank[23], bank[24], bank[25]});
    assign SWEEP_PERIOD_O = {bank[26][3:0], bank[27], bank[28]};
    assign POWER_DOWN_O = {3'b000, bank[ADDR_PWR][PWR_CMP], 1'b0, bank[ADDR_PWR][PWR_AUX:PWR_DIG]};
    assign CLOCK_MULT_O = {1'b0, bank[ADDR_CMUL][CMUL_RANGE:0]};
    assign MODE_O = {bank[ADDR_MODE][MODE_CLR1:MODE_TRI], 1'b0,
                     bank[ADDR_MODE][MODE_SEL_HI:MODE_INTUPD]};
    assign OUTPUT_CTRL_O = {1'b0, bank[ADDR_OUT][OUT_SINC:OUT_KINT], 2'b00,
                            bank[ADDR_OUT][OUT_LSB:OUT_SDO]};
    assign KEYING_MULT_O = {bank[33][3:0], bank[34]};
    assign KEYING_RAMP_O = bank[BASE_KRAMP];
    assign AUX_VALUE_O = {bank[38][3:0], bank[39]};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reset_aborts: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        s_iorst[1] |=> !phase_data) else $error("io reset did not abort");
    a_write_lands: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (byte_done && !rd_mode) |=> buffer[$past(ptr)] == $past(in_byte))
        else $error("write byte lost");
    a_copy_bank: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (s_ref[1] && !ref_d) |=> bank[ADDR_MODE] == $past(buffer[ADDR_MODE]))
        else $error("reference start did not copy");
    a_no_drive_write: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        !rd_mode |-> !SDIO_OE_O && !SERIAL_OUTPUT_LINE_OE_O)
        else $error("drove data on write");
    a_instr_phase: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        instr_done |=> phase_data) else $error("instruction not taken");
    a_pwr_rsvd: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        !POWER_DOWN_O[PWR_RSVD] && !(ptr == ADDR_PWR && rd_byte[PWR_RSVD]))
        else $error("reserved power bit high");
    a_ptr_limit: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        phase_data |-> ptr <= last_ptr) else $error("pointer past register");
    a_strap_off: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        s_sel[1] |=> !phase_data) else $error("serial active with strap high");
    a_cycle_close: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (byte_done && ptr == last_ptr) |=> ##1 !phase_data)
        else $error("cycle did not close");
endmodule
`default_nettype wire

// ===== dsc_host_model.sv
// dsc_host_model: behavioural serial master for the configuration port
// assumes: clk_i is the system clock; the bench calls xfer and partial
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
    input wire logic clk_i,
    input wire logic sdio_o_i,
    input wire logic sdio_oe_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic io_rst_o,
    output logic sdio_o
);
    logic drive = 1'b0;
    logic dval = 1'b0;
    logic spin = 1'b0;
    logic skip_end = 1'b0;
    logic sdo_wire;
    int bad_oe = 0;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_rst_o = 1'b0;
    end
    // --------------------------------
    // wire levels
    // --------------------------------
    // released lines toggle so a stale level never passes for data
    always @(posedge clk_i) spin <= ~spin;
    assign sdio_o = sdio_oe_i ? sdio_o_i : (drive ? dval : spin);
    assign sdo_wire = sdo_oe_i ? sdo_i : spin;
    // --------------------------------
    // bit and frame tasks
    // --------------------------------
    // clock 800 ns, data set at fall
    task automatic bit_cycle(input logic d, input logic sep, output logic q);
        sclk_o <= 1'b0;
        dval <= d;
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        q = sep ? sdo_wire : sdio_o;
        if (sep && sdio_oe_i) bad_oe++;
        @(posedge clk_i);
    endtask
    // io reset after a frame keeps a miscounted edge from spreading
    task automatic end_frame();
        sclk_o <= 1'b0;
        io_rst_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        io_rst_o <= 1'b0;
        cs_n_o <= 1'b1;
        drive <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic xfer(input logic [7:0] ins, input int nb, input logic [47:0] wd,
                        input logic lsb, input logic sep, output logic [47:0] rd);
        logic [7:0] bv;
        logic q;
        int b;
        int i;
        int k;
        rd = 48'h0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        drive <= 1'b1;
        for (i = 7; i >= 0; i--) bit_cycle(ins[i], sep, q);
        drive <= ~ins[7];
        for (b = nb - 1; b >= 0; b--) begin
            bv = wd[8*b +: 8];
            for (i = 0; i < 8; i++) begin
                k = lsb ? i : 7 - i;
                bit_cycle(bv[k], sep, q);
                bv[k] = q;
            end
            rd[8*b +: 8] = bv;
        end
        // skip_end chains the next instruction straight after the last byte
        if (!skip_end) begin
            end_frame();
        end
    endtask
    task automatic partial(input int n);
        logic q;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        drive <= 1'b1;
        repeat (n) bit_cycle(1'b1, 1'b0, q);
        end_frame();
    endtask
endmodule
`default_nettype wire

// ===== test_dds_serial_config_port.sv
// test_dds_serial_config_port: self-checking bench for dsc_port
// assumes: dsc_host_model plays the serial master, 10 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            $display("unexpected %s expected %h seen %h", nm, exp, got); \
            n_fail++; \
        end \
    end
module test_dds_serial_config_port
    import dsc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sel_n = 1'b0;
    logic update = 1'b0;
    logic refrun = 1'b0;
    logic lsb = 1'b0;
    logic sep = 1'b0;
    logic sclk, cs_n, io_rst, sdio, sdio_q, sdio_oe, serial_output_line, sdo_oe;
    logic [13:0] ph1, ph2;
    logic [47:0] ftw1, ftw2, step;
    logic [31:0] upd;
    logic [19:0] ramp;
    logic [7:0] pwr, cmul, mode, outc, kramp;
    logic [11:0] kmul, aux;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    int ra[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11};
    int rn[11] = '{2, 2, 6, 6, 6, 4, 3, 4, 2, 1, 2};
    logic [47:0] wv[11] = '{48'hC123, 48'h7ABC, 48'h1234_5678_9ABC, 48'hFEDC_BA98_7654,
        48'h0F1E_2D3C_4B5A, 48'hDEAD_BEEF, 48'hF5_A5A5, 48'h1F45_E070, 48'hF9AB, 48'h5C,
        48'hF321};
    logic [47:0] mk[11] = '{48'h3FFF, 48'h3FFF, 48'hFFFF_FFFF_FFFF, 48'hFFFF_FFFF_FFFF,
        48'hFFFF_FFFF_FFFF, 48'hFFFF_FFFF, 48'h0F_FFFF, 48'hF7FF_FFFF, 48'h0FFF, 48'hFF,
        48'h0FFF};
    always #50 mclk = ~mclk;
    dsc_port #(.UPD_WIDTH(32)) u_dut (.MCLK_I(mclk), .RESET_I(rst), .SERIAL_SEL_N_I(sel_n),
        .SCLK_I(sclk), .CS_N_I(cs_n), .IO_RESET_I(io_rst), .SDIO_I(sdio), .SDIO_O(sdio_q),
        .SDIO_OE_O(sdio_oe), .SERIAL_OUTPUT_LINE_O(serial_output_line), .SERIAL_OUTPUT_LINE_OE_O(sdo_oe),
        .UPDATE_I(update), .REFERENCE_CLOCK_RUN_I(refrun), .PHASE_ONE_O(ph1),
        .PHASE_TWO_O(ph2), .TUNING_ONE_O(ftw1), .TUNING_TWO_O(ftw2), .SWEEP_STEP_O(step),
        .UPDATE_PERIOD_O(upd), .SWEEP_PERIOD_O(ramp), .POWER_DOWN_O(pwr),
        .CLOCK_MULT_O(cmul), .MODE_O(mode), .OUTPUT_CTRL_O(outc), .KEYING_MULT_O(kmul),
        .KEYING_RAMP_O(kramp), .AUX_VALUE_O(aux));
    dsc_host_model u_host (.clk_i(mclk), .sdio_o_i(sdio_q), .sdio_oe_i(sdio_oe),
        .sdo_i(serial_output_line), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n), .io_rst_o(io_rst),
        .sdio_o(sdio));
    // --------------------------------
    // access tasks
    // --------------------------------
    task automatic wr(input int a, input int n, input logic [47:0] v);
        logic [47:0] d;
        u_host.xfer({4'h0, 4'(a)}, n, v, lsb, sep, d);
    endtask
    task automatic rd(input int a, input int n, output logic [47:0] d);
        u_host.xfer({4'h8, 4'(a)}, n, 48'h0, lsb, sep, d);
    endtask
    task automatic pulse_update();
        update <= 1'b1;
        repeat (2) @(posedge mclk);
        update <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    function automatic logic [47:0] bank(input int a);
        case (a)
            0: return 48'(ph1);
            1: return 48'(ph2);
            2: return ftw1;
            3: return ftw2;
            4: return step;
            5: return 48'(upd);
            6: return 48'(ramp);
            7: return {16'h0, pwr, cmul, mode, outc};
            8: return 48'(kmul);
            10: return 48'(kramp);
            default: return 48'(aux);
        endcase
    endfunction
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard: the full run needs about 9000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            conclude();
        end
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        logic [47:0] d;
        logic [47:0] e;
        int i;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        for (i = 0; i < 11; i++) begin
            e = (ra[i] == 7) ? {16'h0, RST_PWR, RST_CMUL, RST_MODE, RST_OUT} :
                (ra[i] == 10) ? 48'(RST_KRAMP) : 48'h0;
            `CHK("bank default", e, bank(ra[i]));
        end
        rd(7, 4, d);
        `CHK("control readback", 48'h1064_0120, d);
        for (i = 0; i < 11; i++) wr(ra[i], rn[i], wv[i]);
        `CHK("bank before update", 48'h0, bank(2));
        pulse_update();
        for (i = 0; i < 11; i++) begin
            `CHK("bank value", wv[i] & mk[i], bank(ra[i]));
            rd(ra[i], rn[i], d);
            `CHK("readback", wv[i] & mk[i], d & mk[i]);
            if (ra[i] == 7) `CHK("reserved power readback", 1'b0, d[27]);
        end
        wr(10, 1, 48'h33);
        `CHK("ramp before clock start", 48'h5C, bank(10));
        // buffer written before the clock starts, no update pulse
        refrun <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK("ramp after clock start", 48'h33, bank(10));
        sel_n <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(10, 1, 48'h99);
        sel_n <= 1'b0;
        repeat (4) @(posedge mclk);
        pulse_update();
        `CHK("ramp with strap high", 48'h33, bank(10));
        u_host.partial(5);
        wr(10, 1, 48'h6E);
        pulse_update();
        `CHK("ramp after abort", 48'h6E, bank(10));
        // cycle closes after its last byte, no io reset in between
        u_host.skip_end = 1'b1;
        wr(10, 1, 48'hA7);
        u_host.skip_end = 1'b0;
        wr(8, 2, 48'h0155);
        pulse_update();
        `CHK("chained ramp", 48'hA7, bank(10));
        `CHK("chained multiplier", 48'h0155, bank(8));
        wr(7, 4, 48'h1064_0123);
        pulse_update();
        `CHK("output control", 48'h1064_0123, bank(7));
        lsb = 1'b1;
        sep = 1'b1;
        wr(3, 6, 48'h0011_2233_4455);
        rd(3, 6, d);
        `CHK("lsb separate readback", 48'h0011_2233_4455, d);
        pulse_update();
        `CHK("lsb bank value", 48'h0011_2233_4455, bank(3));
        `CHK("shared pin enable", 0, u_host.bad_oe);
        conclude();
    end
endmodule
`default_nettype wire
